// >>> ussf_pkg.sv
// Shared constants and types for the serial-engine status flags.
// Assumes one clock domain shared by both ends.
package ussf_pkg;

  // ----------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_W     = 16;
  localparam int unsigned F_SETUP    = 0;
  localparam int unsigned F_IN_RCVD  = 1;
  localparam int unsigned F_OUT_DONE = 2;
  localparam int unsigned F_IN_SENT  = 3;
  localparam int unsigned F_HALTED   = 4;
  localparam int unsigned F_NAK      = 5;
  localparam int unsigned F_TIMEOUT  = 6;
  localparam int unsigned F_TOGGLE   = 7;
  localparam int unsigned F_ATTACH   = 8;
  localparam int unsigned F_RST_BEG  = 9;
  localparam int unsigned F_RST_END  = 10;
  localparam int unsigned F_FAST     = 11;
  localparam int unsigned F_SLOW     = 12;
  localparam int unsigned F_SUSPEND  = 13;
  localparam int unsigned F_RESUME   = 14;

  // Flags the engine itself updates, never sticky
  localparam logic [15:0] LIVE_MASK  = 16'h1900;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Controller register map (word offsets)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0] A_FLAGS   = 4'h0;
  localparam logic [3:0] A_CLEAR   = 4'h1;
  localparam logic [3:0] A_CTRL    = 4'h2;
  localparam logic [3:0] A_EXPECT  = 4'h3;
  localparam logic [3:0] A_STATUS  = 4'h4;
  localparam int unsigned C_ROLE   = 0;
  localparam int unsigned C_SINGLE = 1;
  localparam int unsigned S_ARMED  = 0;
  localparam int unsigned S_DONE   = 1;

  // Transaction outcome codes
  typedef enum logic [2:0] {
    USSF_OK      = 3'h0,
    USSF_STALL   = 3'h1,
    USSF_NAK     = 3'h2,
    USSF_TIMEOUT = 3'h3,
    USSF_TOGGLE  = 3'h4
  } ussf_outcome_e;

  typedef enum logic [1:0] {
    USSF_SETUP = 2'h0,
    USSF_IN    = 2'h1,
    USSF_OUT   = 2'h2
  } ussf_kind_e;

  typedef enum logic [1:0] {
    USSF_SPD_FULL = 2'h0,
    USSF_SPD_HIGH = 2'h1,
    USSF_SPD_LOW  = 2'h2
  } ussf_speed_e;

endpackage

// >>> ussf_if.sv
// Carrier between the flag engine and its controlling logic.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface ussf_if;
  logic                           role_host;
  logic                           single_try_option;
  logic                           flag_clear_instruction;
  logic [ussf_pkg::FLAG_W-1:0]    clear_mask;
  logic [ussf_pkg::FLAG_W-1:0]    flags;

  modport engine (
    input  role_host,
    input  single_try_option,
    input  flag_clear_instruction,
    input  clear_mask,
    output flags
  );
  modport ctrl (
    output role_host,
    output single_try_option,
    output flag_clear_instruction,
    output clear_mask,
    input  flags
  );
endinterface

// >>> ussf_engine.sv
// Status-flag logic of the serial engine: turns transaction outcomes
// and bus events into flags for the controlling logic, sticky except speed and attached.
// Assumes event pulses are one clk_sys cycle wide and synchronous.
//
// Notes on behaviour
// (R1) Host SETUP NAK sets unexpected NAK
// (R2) Device illegal IN NAK sets unexpected NAK
// (R3) Controller clears NAK flag before arming
// (R4) Host timeout sets timeout flag
// (R5) Host single-try: exactly one outcome flag; here an IN or OUT NAK sets none
// (R6) Host retries: check completion before timeout
// (R7) Device timeout flag for IN only
// (R8) Device single-try: one IN outcome flag
// (R9) Pull-up connect sets attached flag
// (R10) Disconnect or VBUS low clears attached
// (R11) Controller uses D+ level, not attached
// (R12) Device reset start sets begun flag
// (R13) Device reset end sets finished flag
// (R14) Host reset updates fast-link flag
// (R15) Host reset updates slow-link flag
// (R16) Host suspend command or LPM sets suspend
// (R17) Device suspended by partner sets suspend
// (R18) Host resumed by partner sets resume
// (R19) Device resumed by partner sets resume
// (R20) Host stall sets halted instead
// (R21) Flags sticky except speed and attached
`timescale 1ns/1ps
module ussf_engine (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  ussf_if.engine                     bus,
  input  wire logic                  txn_done,
  input  wire ussf_pkg::ussf_kind_e  txn_kind,
  input  wire ussf_pkg::ussf_outcome_e txn_outcome,
  input  wire logic                  txn_retry,
  input  wire logic                  connect_pulse,
  input  wire logic                  disconnect_pulse,
  input  wire logic                  session_valid,
  input  wire logic                  reset_start_pulse,
  input  wire logic                  reset_end_pulse,
  input  wire ussf_pkg::ussf_speed_e reset_speed,
  input  wire logic                  suspend_begin_command,
  input  wire logic                  lpm_done,
  input  wire logic                  suspended_by_peer,
  input  wire logic                  resumed_by_peer
);

  logic [ussf_pkg::FLAG_W-1:0] flags_reg;
  logic [ussf_pkg::FLAG_W-1:0] flags_next;
  logic [ussf_pkg::FLAG_W-1:0] set_v;
  logic                        host;
  logic                        report;

  assign host = bus.role_host;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  always_comb begin
    set_v  = '0;
    // Retried timeouts still report unless single-try, but a final outcome follows [R6]
    report = txn_done && (host || txn_kind == ussf_pkg::USSF_IN);
    if (report) begin
      unique case (txn_outcome)
        ussf_pkg::USSF_OK: begin
          if (!host)
            set_v[ussf_pkg::F_IN_SENT] = 1'b1;
          else if (txn_kind == ussf_pkg::USSF_SETUP)
            set_v[ussf_pkg::F_SETUP] = 1'b1;
          else if (txn_kind == ussf_pkg::USSF_IN)
            set_v[ussf_pkg::F_IN_RCVD] = 1'b1;
          else
            set_v[ussf_pkg::F_OUT_DONE] = 1'b1;
        end
        ussf_pkg::USSF_STALL: set_v[ussf_pkg::F_HALTED] = 1'b1; // [R20]
        ussf_pkg::USSF_NAK: begin
          // Host NAK counts only for SETUP; IN NAK is normal flow
          if (!host || txn_kind == ussf_pkg::USSF_SETUP)
            set_v[ussf_pkg::F_NAK] = 1'b1; // [R1] [R2]
        end
        ussf_pkg::USSF_TIMEOUT: begin
          set_v[ussf_pkg::F_TIMEOUT] = 1'b1; // [R4] [R7]
        end
        ussf_pkg::USSF_TOGGLE: begin
          if (host)
            set_v[ussf_pkg::F_TOGGLE] = 1'b1;
        end
        default: set_v = '0;
      endcase
      // Single-try: a retried attempt posts nothing, at most one flag per txn
      if (txn_retry && !bus.single_try_option &&
          txn_outcome == ussf_pkg::USSF_TIMEOUT) begin
        set_v = set_v; // timeout visible while retrying
      end else if (txn_retry && bus.single_try_option) begin
        set_v = '0; // [R5] [R8]
      end
    end
    if (!host) begin
      set_v[ussf_pkg::F_RST_BEG] = reset_start_pulse; // [R12]
      set_v[ussf_pkg::F_RST_END] = reset_end_pulse;   // [R13]
      set_v[ussf_pkg::F_SUSPEND] = suspended_by_peer; // [R17]
    end else begin
      set_v[ussf_pkg::F_SUSPEND] = suspend_begin_command || lpm_done; // [R16]
    end
    set_v[ussf_pkg::F_RESUME] = resumed_by_peer; // [R18] [R19]
  end

  // ----------------------------------------------------------------
  // Flag update: set wins over clear, except attached, where clear wins
  // ----------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    if (bus.flag_clear_instruction)
      flags_next = flags_next & ~(bus.clear_mask & ~ussf_pkg::LIVE_MASK);
    flags_next = flags_next | (set_v & ~ussf_pkg::LIVE_MASK); // [R21]
    if (connect_pulse)
      flags_next[ussf_pkg::F_ATTACH] = 1'b1; // [R9]
    if (disconnect_pulse || !session_valid)
      flags_next[ussf_pkg::F_ATTACH] = 1'b0; // [R10]
    if (host && reset_end_pulse) begin
      flags_next[ussf_pkg::F_FAST] =
        (reset_speed == ussf_pkg::USSF_SPD_HIGH); // [R14]
      flags_next[ussf_pkg::F_SLOW] =
        (reset_speed == ussf_pkg::USSF_SPD_LOW);  // [R15]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      flags_reg <= ussf_pkg::FLAG_RESET;
    else
      flags_reg <= flags_next;
  end

  assign bus.flags = flags_reg;

endmodule

// >>> ussf_ctrl.sv
// Controlling end: software register port over the status flags.
// Assumes the engine's flags interface on the same clk_sys.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module ussf_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  ussf_if.ctrl                             bus,
  input  wire logic [ussf_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic [31:0]                      rdata,
  output logic                             txn_enable
);

  typedef enum logic [1:0] {
    USSF_IDLE = 2'b00,
    USSF_ARM  = 2'b01,
    USSF_WAIT = 2'b11
  } ussf_state_e;

  ussf_state_e                 state_reg, state_next;
  logic [1:0]                  ctrl_reg, ctrl_next;
  logic [ussf_pkg::FLAG_W-1:0] expect_reg, expect_next;
  logic [31:0]                 rdata_reg, rdata_next;
  logic                        done_reg, done_next;
  logic                        clr_v;
  logic [ussf_pkg::FLAG_W-1:0] mask_v;

  // ----------------------------------------------------------------
  // Register port and arming sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    ctrl_next   = ctrl_reg;
    expect_next = expect_reg;
    done_next   = done_reg;
    rdata_next  = '0;
    clr_v       = 1'b0;
    mask_v      = '0;
    if (wr) begin
      unique case (addr)
        ussf_pkg::A_CLEAR: begin
          clr_v  = 1'b1;
          mask_v = wdata[ussf_pkg::FLAG_W-1:0];
        end
        ussf_pkg::A_CTRL:   ctrl_next = wdata[1:0];
        ussf_pkg::A_EXPECT: begin
          expect_next = wdata[ussf_pkg::FLAG_W-1:0];
          done_next   = 1'b0;
          state_next  = USSF_ARM;
        end
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        ussf_pkg::A_FLAGS:  rdata_next[ussf_pkg::FLAG_W-1:0] = bus.flags;
        ussf_pkg::A_CTRL:   rdata_next[1:0] = ctrl_reg;
        ussf_pkg::A_EXPECT: rdata_next[ussf_pkg::FLAG_W-1:0] = expect_reg;
        ussf_pkg::A_STATUS: begin
          rdata_next[ussf_pkg::S_ARMED] = (state_reg == USSF_WAIT);
          rdata_next[ussf_pkg::S_DONE]  = done_reg;
        end
        default: rdata_next = '0;
      endcase
    end
    unique case (state_reg)
      USSF_IDLE: ;
      // Stale NAK would mask the new outcome, so clear it first [R3]
      USSF_ARM: begin
        if (!wr) begin
          clr_v      = 1'b1;
          mask_v     = expect_reg;
          mask_v[ussf_pkg::F_NAK]     = 1'b1;
          mask_v[ussf_pkg::F_TIMEOUT] = 1'b1;
          state_next = USSF_WAIT;
        end
      end
      // Completion flags decide; timeout alone is not final [R6]
      USSF_WAIT: begin
        if ((bus.flags & expect_reg) != '0) begin
          done_next  = 1'b1;
          state_next = USSF_IDLE;
        end
      end
      default: state_next = USSF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg  <= USSF_IDLE;
      ctrl_reg   <= 2'h0;
      expect_reg <= '0;
      done_reg   <= 1'b0;
      rdata_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      expect_reg <= expect_next;
      done_reg   <= done_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata                      = rdata_reg;
  assign txn_enable                 = (state_reg == USSF_WAIT);
  assign bus.role_host              = ctrl_reg[ussf_pkg::C_ROLE];
  assign bus.single_try_option      = ctrl_reg[ussf_pkg::C_SINGLE];
  assign bus.flag_clear_instruction = clr_v;
  assign bus.clear_mask             = mask_v;

endmodule

// >>> ussf_asserts.sv
// Checker for the flag carrier between engine and controller.
// Assumes one instance beside the interface, all on clk_sys.
`timescale 1ns/1ps
module ussf_asserts (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        role_host,
  input wire logic                        single_try_option,
  input wire logic                        flag_clear_instruction,
  input wire logic [ussf_pkg::FLAG_W-1:0] clear_mask,
  input wire logic [ussf_pkg::FLAG_W-1:0] flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // One cycle of grace after a clear, in case the engine registers it
  logic [15:0] cut_reg, cut_next, hold_reg, hold_next;
  always_comb begin
    cut_next  = flag_clear_instruction ? clear_mask : 16'h0000;
    hold_next = flags & ~cut_next & ~cut_reg;
  end
  always_ff @(posedge clk_sys) begin
    cut_reg  <= rst ? 16'h0000 : cut_next;
    hold_reg <= rst ? 16'h0000 : hold_next;
  end

  nak_hold_a: assert property (hold_reg[5] |-> flags[5])
    else $error("nak flag fell uncleared");
  timeout_hold_a: assert property (hold_reg[6] |-> flags[6])
    else $error("timeout flag fell uncleared");
  begun_hold_a: assert property (hold_reg[9] |-> flags[9])
    else $error("reset begun flag fell uncleared");
  finished_hold_a: assert property (hold_reg[10] |-> flags[10])
    else $error("reset finished flag fell uncleared");
  suspend_hold_a: assert property (hold_reg[13] |-> flags[13])
    else $error("suspend flag fell uncleared");
  resume_hold_a: assert property (hold_reg[14] |-> flags[14])
    else $error("resume flag fell uncleared");
  single_outcome_a: assert property (single_try_option
    |-> $countones(flags[7:0] & ~$past(flags[7:0])) <= 1)
    else $error("two outcome flags rose together");
  dev_in_only_a: assert property (!role_host && !$past(role_host)
    |-> (flags & ~$past(flags) & 16'h0087) == 16'h0000)
    else $error("host flag rose in device role");
  host_no_sent_a: assert property (role_host && $past(role_host)
    |-> !$rose(flags[3]))
    else $error("in sent flag rose in host role");
  speed_excl_a: assert property ($onehot0(flags[12:11]))
    else $error("fast and slow both set");
  dev_speed_a: assert property (!role_host && !$past(role_host)
    |-> $stable(flags[12:11]))
    else $error("speed moved in device role");
endmodule

// >>> usb_sie_status_flags_bench.sv
// Bench: engine and controller joined by one carrier, checked by reads.
// Assumes the register map and encodings of ussf_pkg.
`timescale 1ns/1ps
module usb_sie_status_flags_bench;
  localparam logic [3:0] FL = ussf_pkg::A_FLAGS;
  localparam logic [3:0] CL = ussf_pkg::A_CLEAR;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  logic [3:0]              addr = 4'h0;
  logic [31:0]             wdata = 32'h0;
  logic [31:0]             rdata;
  logic                    txn_en;
  logic                    wr = 1'b0;
  logic                    rd = 1'b0;
  logic                    rd_d = 1'b0;
  logic                    retry = 1'b0;
  logic                    sess = 1'b1;
  logic [8:0]              pv = 9'h000;
  ussf_pkg::ussf_kind_e    kind = ussf_pkg::USSF_SETUP;
  ussf_pkg::ussf_outcome_e outc = ussf_pkg::USSF_OK;
  ussf_pkg::ussf_speed_e   spd = ussf_pkg::USSF_SPD_FULL;
  logic [31:0]             exp_q[$];
  int                      miscompares = 0;
  int                      checks_done = 0;
  int                      seed = 32'h322b3812;

  ussf_if bus_if ();
  ussf_engine ussf_engine_inst (
    .clk_sys(clk_sys), .rst(rst), .bus(bus_if.engine), .txn_done(pv[8]),
    .txn_kind(kind), .txn_outcome(outc), .txn_retry(retry),
    .connect_pulse(pv[0]), .disconnect_pulse(pv[1]), .session_valid(sess),
    .reset_start_pulse(pv[2]), .reset_end_pulse(pv[3]), .reset_speed(spd),
    .suspend_begin_command(pv[4]), .lpm_done(pv[5]),
    .suspended_by_peer(pv[6]), .resumed_by_peer(pv[7]));
  ussf_ctrl ussf_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst), .bus(bus_if.ctrl), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txn_enable(txn_en));
  ussf_asserts ussf_asserts_inst (
    .clk_sys(clk_sys), .rst(rst), .role_host(bus_if.role_host),
    .single_try_option(bus_if.single_try_option),
    .flag_clear_instruction(bus_if.flag_clear_instruction),
    .clear_mask(bus_if.clear_mask), .flags(bus_if.flags));

  always #2 clk_sys = ~clk_sys;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t read %h want %h", $time, seen, want);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
  endtask

  task automatic fire(input int i);
    @(posedge clk_sys);
    pv[i] <= 1'b1;
    @(posedge clk_sys);
    pv <= 9'h000;
    repeat (2) @(posedge clk_sys);
  endtask

  // Sticky flags cleared for every event, attached and speed kept, so each read shows one cause
  task automatic step(input logic [1:0] c, input int i, logic [15:0] e);
    wreg(ussf_pkg::A_CTRL, {30'h0, c});
    wreg(CL, 32'h0000ffff);
    repeat (2) @(posedge clk_sys);
    fire(i);
    rreg(FL, {16'h0000, e});
  endtask

  function automatic logic [15:0] txn_exp(input int h, input int k,
                                          input int o);
    int b;
    txn_exp = 16'h0000;
    case (o)
      0: b = h == 0 ? ussf_pkg::F_IN_SENT : k == 1 ? ussf_pkg::F_IN_RCVD :
             k == 2 ? ussf_pkg::F_OUT_DONE : ussf_pkg::F_SETUP;
      1: b = ussf_pkg::F_HALTED;
      2: b = (h == 0 || k == 0) ? ussf_pkg::F_NAK : 16;
      3: b = ussf_pkg::F_TIMEOUT;
      default: b = h != 0 ? ussf_pkg::F_TOGGLE : 16;
    endcase
    if (h == 0 && k != 1)
      b = 16;
    if (b < 16)
      txn_exp[b] = 1'b1;
  endfunction

  always @(posedge clk_sys) begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, exp_q.pop_front());
  end

  initial begin
    #50000;
    miscompares++;
    final_report();
  end

  initial begin
    int r;
    logic [15:0] e;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rreg(FL, 32'h0);
    rreg(4'hf, 32'h0);
    for (int h = 0; h < 2; h++)
      for (int k = 0; k < 3; k++)
        for (int o = 0; o < 5; o++) begin
          r = $random(seed) & 1;
          kind  <= ussf_pkg::ussf_kind_e'(k);
          outc  <= ussf_pkg::ussf_outcome_e'(o);
          retry <= r[0];
          e = r[0] ? 16'h0000 : txn_exp(h, k, o);
          step({1'b1, h[0]}, 8, e);
        end
    kind  <= ussf_pkg::USSF_SETUP;
    outc  <= ussf_pkg::USSF_TIMEOUT;
    retry <= 1'b1;
    step(2'b01, 8, 16'h0040);
    step(2'b00, 2, 16'h0200);
    fire(3);
    rreg(FL, 32'h0600);
    wreg(CL, 32'h0200);
    repeat (2) @(posedge clk_sys);
    rreg(FL, 32'h0400);
    step(2'b00, 6, 16'h2000);
    step(2'b00, 7, 16'h4000);
    step(2'b01, 4, 16'h2000);
    step(2'b01, 5, 16'h2000);
    step(2'b01, 7, 16'h4000);
    for (int s = 1; s < 4; s++) begin
      spd <= ussf_pkg::ussf_speed_e'(s % 3);
      e = s == 1 ? 16'h0800 : s == 2 ? 16'h1000 : 16'h0000;
      step(2'b01, 3, e);
    end
    spd <= ussf_pkg::USSF_SPD_HIGH;
    step(2'b00, 3, 16'h0400);
    step(2'b01, 0, 16'h0100);
    step(2'b01, 1, 16'h0000);
    step(2'b01, 0, 16'h0100);
    sess <= 1'b0;
    step(2'b01, 0, 16'h0000);
    sess  <= 1'b1;
    kind  <= ussf_pkg::USSF_SETUP;
    outc  <= ussf_pkg::USSF_NAK;
    retry <= 1'b0;
    step(2'b01, 8, 16'h0020);
    kind <= ussf_pkg::USSF_IN;
    outc <= ussf_pkg::USSF_OK;
    // Arming must wipe the stale NAK before the transfer runs
    wreg(ussf_pkg::A_EXPECT, 32'h00000002);
    rreg(FL, 32'h0);
    rreg(ussf_pkg::A_STATUS, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, txn_en}, 32'h1);
    fire(8);
    rreg(ussf_pkg::A_STATUS, 32'h2);
    rreg(ussf_pkg::A_EXPECT, 32'h2);
    rreg(ussf_pkg::A_CTRL, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, txn_en}, 32'h0);
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule
